// ---- design/pio_cell.sv ----
// ==========================================================================
// storage register of one i/o cell with async clear and preset
// ==========================================================================
module pio_cell
    import pio_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // data and power-up value
    input wire logic d_i,
    input wire logic init_i,
    // asynchronous controls, already qualified and registered
    input wire logic clr_i,
    input wire logic pre_i,
    // register value
    output logic q_o
);

    // state of the cell
    typedef struct packed {
        logic q; // stored bit
    } pio_cell_t;

    pio_cell_t s_q; // registered state
    pio_cell_t s_d; // next state

    // ======================================================================
    // next value: power-up value during reset, else data
    // ======================================================================
    always_comb begin
        s_d = s_q;
        if (rst_i) begin
            s_d.q = init_i;
        end else begin
            s_d.q = d_i;
        end
    end

    // clear has priority over preset; both act without the clock
    always_ff @(posedge clk_i or posedge clr_i or posedge pre_i) begin
        if (clr_i) begin
            s_q <= '0;
        end else if (pre_i) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.q;

    // ======================================================================
    // checks
    // ======================================================================
    a_clear_low: assert property (@(posedge clk_i)
        clr_i |-> !q_o)
        else $error("cell register not low under clear");

    a_preset_high: assert property (@(posedge clk_i)
        (pre_i && !clr_i) |-> q_o)
        else $error("cell register not high under preset");

    a_init_load: assert property (@(posedge clk_i)
        (rst_i && !clr_i && !pre_i) ##1 (!clr_i && !pre_i)
        |-> q_o == $past(init_i))
        else $error("cell register missed its power-up value");

    a_data_follow: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (!clr_i && !pre_i) ##1 (!clr_i && !pre_i) |-> q_o == $past(d_i))
        else $error("cell register did not take its data");

endmodule : pio_cell

// ---- design/pio_pkg.sv ----
// ==========================================================================
// shared constants of the programmable i/o cell block
// ==========================================================================
package pio_pkg;

    // ======================================================================
    // wishbone register byte addresses (one aligned 32-bit word each)
    // ======================================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00; // global enable and clear
    localparam logic [7:0] ADDR_MODE = 8'h04; // two mode bits per pin
    localparam logic [7:0] ADDR_USE = 8'h08; // cell register use per pin
    localparam logic [7:0] ADDR_INV = 8'h0C; // core data inversion per pin
    localparam logic [7:0] ADDR_INIT = 8'h10; // power-up value per pin
    localparam logic [7:0] ADDR_DOUT = 8'h14; // core output data per pin
    localparam logic [7:0] ADDR_OE = 8'h18; // per-pin output enable
    localparam logic [7:0] ADDR_STAT = 8'h1C; // captured pins, cell values
    localparam logic [7:0] ADDR_ACLR = 8'h20; // per-pin async clear level
    localparam logic [7:0] ADDR_APRE = 8'h24; // per-pin async preset level

    // ======================================================================
    // control register fields
    // ======================================================================
    localparam int CTRL_GOE_BIT = 0; // device-wide output enable
    localparam int CTRL_GCLR_BIT = 1; // device-wide clear
    localparam int CTRL_W = 2; // implemented control bits
    localparam logic [1:0] CTRL_RST = 2'h0; // drivers off, no clear

    // status register layout: capture in low half, cell values above
    localparam int STAT_CELL_POS = 16; // first bit of the cell values

    // ======================================================================
    // pin modes
    // ======================================================================
    localparam logic [1:0] MODE_IN = 2'h0; // input only, never drives
    localparam logic [1:0] MODE_OUT = 2'h1; // output only, always drives
    localparam logic [1:0] MODE_BIDIR = 2'h2; // driver under per-pin enable
    localparam logic [1:0] MODE_OD = 2'h3; // open drain, low or released
    localparam int MODE_W = 2; // mode field width

    // reset values of the per-pin registers
    localparam logic [31:0] PIN_RST = 32'h0000_0000; // all per-pin fields
    localparam logic [31:0] RDAT_RST = 32'h0000_0000; // read data idle

endpackage : pio_pkg

// ---- design/pio_regs.sv ----
// Summary of operation
// - cell register serves as input or output register
// - pins are input, output or bidirectional
// - each pin has its own output enable
// - optional inversion of core data into cell
// - cell register power-up value selectable high/low; reset also clears init, so cells load low from the second reset cycle on
// - low-init register forced low by async clear
// - basic variant: high-init register no async control
// - enhanced variant: high-init register takes async preset
// - enhanced variant has native open-drain output mode
// - enable and capture registers live in core logic
module pio_regs
    import pio_pkg::*;
#(
    parameter int N_PINS = 8, // pins served, at most 16
    parameter bit ENHANCED = 1'b1 // enhanced cell variant
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // package pins, split into in, out and active-low enable
    input wire logic [N_PINS-1:0] pad_i,
    output logic [N_PINS-1:0] pad_o,
    output logic [N_PINS-1:0] pad_oe_n_o
);

    // ======================================================================
    // state
    // ======================================================================
    localparam int N = N_PINS; // short alias
    localparam int MW = MODE_W * N_PINS; // width of the mode register

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl; // global enable and clear
        logic [MW-1:0] mode; // pin modes
        logic [N-1:0] use_out; // 1: cell register drives the pin
        logic [N-1:0] inv; // invert core data
        logic [N-1:0] init; // power-up value of each cell
        logic [N-1:0] dout; // core output data
        logic [N-1:0] oe; // core output enable registers
        logic [N-1:0] aclr; // async clear request levels
        logic [N-1:0] apre; // async preset request levels
        logic [N-1:0] cclr; // qualified clear to the cells
        logic [N-1:0] cpre; // qualified preset to the cells
        logic [N-1:0] sync1; // first synchroniser stage
        logic [N-1:0] sync2; // second synchroniser stage
        logic [N-1:0] cap; // core input capture registers
        logic [N-1:0] pad; // registered pin data
        logic [N-1:0] pad_oe_n; // registered pin enables, low drives
        logic ack; // wishbone acknowledge
        logic [31:0] rdat; // wishbone read data
    } pio_state_t;

    pio_state_t s_q; // registered state
    pio_state_t s_d; // next state

    logic [N-1:0] cell_q; // values of the cell registers
    logic [N-1:0] cell_d; // data into the cell registers
    logic [N-1:0] core_data; // core data after optional inversion
    logic [N-1:0] od_vec; // pins in native open-drain mode
    logic wb_req; // new bus request this cycle

    // ======================================================================
    // helpers
    // ======================================================================

    // merge write data into an old word under the byte lanes
    function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wdat[8*b +: 8];
            end
        end
        return res;
    endfunction : wb_merge

    // mode of one pin, native open drain only in the enhanced variant
    function automatic logic [1:0] pin_mode(input logic [MW-1:0] m,
                                            input int idx);
        logic [1:0] md;
        md = m[MODE_W*idx +: MODE_W];
        if (md == MODE_OD && !ENHANCED) begin
            md = MODE_BIDIR; // basic cell treats open drain as bidirectional
        end
        return md;
    endfunction : pin_mode

    // ======================================================================
    // cell registers
    // ======================================================================

    // inversion and cell data selection per pin
    always_comb begin
        core_data = s_q.dout ^ s_q.inv;
        for (int i = 0; i < N; i++) begin
            // output use takes core data, input use takes the pin
            cell_d[i] = s_q.use_out[i] ? core_data[i] : s_q.sync2[i];
            od_vec[i] = (pin_mode(s_q.mode, i) == MODE_OD);
        end
    end

    // one storage register per pin
    for (genvar g = 0; g < N_PINS; g++) begin : g_cell
        pio_cell u_cell (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .d_i(cell_d[g]),
            .init_i(s_q.init[g]),
            .clr_i(s_q.cclr[g]),
            .pre_i(s_q.cpre[g]),
            .q_o(cell_q[g])
        );
    end

    // ======================================================================
    // next state
    // ======================================================================
    assign wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;

    always_comb begin
        s_d = s_q;

        // pin synchroniser and core capture register
        s_d.sync1 = pad_i;
        s_d.sync2 = s_q.sync1;
        s_d.cap = s_q.sync2;

        // qualified async controls, registered so they cannot glitch
        for (int i = 0; i < N; i++) begin
            // low-init cells clear on their own or the global clear
            s_d.cclr[i] = !s_q.init[i] &&
                (s_q.aclr[i] || s_q.ctrl[CTRL_GCLR_BIT]);
            // high-init cells preset only in the enhanced variant
            s_d.cpre[i] = ENHANCED && s_q.init[i] && s_q.apre[i];
        end

        // pin drivers per mode
        for (int i = 0; i < N; i++) begin
            logic bit_o;
            logic drive;
            bit_o = s_q.use_out[i] ? cell_q[i] : core_data[i];
            drive = 1'b0;
            case (pin_mode(s_q.mode, i))
                // input only: driver always off
                MODE_IN: begin
                    drive = 1'b0;
                end
                // output only: driver always on
                MODE_OUT: begin
                    drive = 1'b1;
                end
                // bidirectional: the core enable register decides
                MODE_BIDIR: begin
                    drive = s_q.oe[i];
                end
                // native open drain: drive only a low
                default: begin
                    drive = s_q.oe[i] && !bit_o;
                    bit_o = 1'b0;
                end
            endcase
            // device-wide enable gates every driver
            drive = drive && s_q.ctrl[CTRL_GOE_BIT];
            s_d.pad[i] = bit_o;
            s_d.pad_oe_n[i] = !drive;
        end

        // bus acknowledge: one cycle after the request, one cycle long
        s_d.ack = wb_req;
        s_d.rdat = RDAT_RST;

        // register writes under byte lanes
        if (wb_req && wb_we_i) begin
            if (wb_adr_i == ADDR_CTRL) begin
                s_d.ctrl = CTRL_W'(wb_merge(32'(s_q.ctrl), wb_dat_i,
                                            wb_sel_i));
            end else if (wb_adr_i == ADDR_MODE) begin
                s_d.mode = MW'(wb_merge(32'(s_q.mode), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADDR_USE) begin
                s_d.use_out = N'(wb_merge(32'(s_q.use_out), wb_dat_i,
                                          wb_sel_i));
            end else if (wb_adr_i == ADDR_INV) begin
                s_d.inv = N'(wb_merge(32'(s_q.inv), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADDR_INIT) begin
                s_d.init = N'(wb_merge(32'(s_q.init), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADDR_DOUT) begin
                s_d.dout = N'(wb_merge(32'(s_q.dout), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADDR_OE) begin
                s_d.oe = N'(wb_merge(32'(s_q.oe), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADDR_ACLR) begin
                s_d.aclr = N'(wb_merge(32'(s_q.aclr), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == ADDR_APRE) begin
                s_d.apre = N'(wb_merge(32'(s_q.apre), wb_dat_i, wb_sel_i));
            end else begin
                // status and unmapped words ignore writes
                s_d.rdat = RDAT_RST;
            end
        end

        // register reads, unmapped words read zero
        if (wb_req && !wb_we_i) begin
            if (wb_adr_i == ADDR_CTRL) begin
                s_d.rdat = 32'(s_q.ctrl);
            end else if (wb_adr_i == ADDR_MODE) begin
                s_d.rdat = 32'(s_q.mode);
            end else if (wb_adr_i == ADDR_USE) begin
                s_d.rdat = 32'(s_q.use_out);
            end else if (wb_adr_i == ADDR_INV) begin
                s_d.rdat = 32'(s_q.inv);
            end else if (wb_adr_i == ADDR_INIT) begin
                s_d.rdat = 32'(s_q.init);
            end else if (wb_adr_i == ADDR_DOUT) begin
                s_d.rdat = 32'(s_q.dout);
            end else if (wb_adr_i == ADDR_OE) begin
                s_d.rdat = 32'(s_q.oe);
            end else if (wb_adr_i == ADDR_STAT) begin
                s_d.rdat = 32'(s_q.cap) | (32'(cell_q) << STAT_CELL_POS);
            end else if (wb_adr_i == ADDR_ACLR) begin
                s_d.rdat = 32'(s_q.aclr);
            end else if (wb_adr_i == ADDR_APRE) begin
                s_d.rdat = 32'(s_q.apre);
            end else begin
                s_d.rdat = RDAT_RST;
            end
        end

        // synchronous reset: configuration defaults, drivers released
        if (rst_i) begin
            s_d.ctrl = CTRL_RST;
            s_d.mode = MW'(PIN_RST);
            s_d.use_out = N'(PIN_RST);
            s_d.inv = N'(PIN_RST);
            s_d.init = N'(PIN_RST);
            s_d.dout = N'(PIN_RST);
            s_d.oe = N'(PIN_RST);
            s_d.aclr = N'(PIN_RST);
            s_d.apre = N'(PIN_RST);
            s_d.cclr = N'(PIN_RST);
            s_d.cpre = N'(PIN_RST);
            s_d.pad = N'(PIN_RST);
            s_d.pad_oe_n = '1;
            s_d.ack = 1'b0;
            s_d.rdat = RDAT_RST;
        end
    end

    // ======================================================================
    // state register
    // ======================================================================
    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    // outputs straight from flip-flops
    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign pad_o = s_q.pad;
    assign pad_oe_n_o = s_q.pad_oe_n;

    // ======================================================================
    // checks
    // ======================================================================
    logic [N-1:0] in_vec; // pins in input-only mode
    always_comb begin
        for (int i = 0; i < N; i++) begin
            in_vec[i] = (pin_mode(s_q.mode, i) == MODE_IN);
        end
    end

    sequence s_wb_read_unmapped;
        wb_req && !wb_we_i && wb_adr_i > ADDR_APRE;
    endsequence

    a_wb_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a one-cycle answer");

    a_wb_unmapped_zero: assert property (@(posedge clk_i)
        disable iff (rst_i)
        s_wb_read_unmapped |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("unmapped read did not return zero");

    a_od_never_high: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (($past(od_vec) & ~pad_oe_n_o & pad_o) == '0))
        else $error("open-drain pin driven high");

    a_goe_gates_all: assert property (@(posedge clk_i) disable iff (rst_i)
        !s_q.ctrl[CTRL_GOE_BIT] |=> &pad_oe_n_o)
        else $error("pin driven while global enable off");

    a_input_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (($past(in_vec) & ~pad_oe_n_o) == '0))
        else $error("input-only pin driven");

    a_bidir_follow_oe: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (s_q.ctrl[CTRL_GOE_BIT] && !od_vec[0] && !in_vec[0] &&
         pin_mode(s_q.mode, 0) == MODE_BIDIR)
        |=> pad_oe_n_o[0] == !$past(s_q.oe[0]))
        else $error("bidirectional pin ignores its enable");

    a_capture_delay: assert property (@(posedge clk_i)
        !rst_i ##1 !rst_i ##1 !rst_i |-> s_q.cap == $past(pad_i, 3))
        else $error("capture register lost pin data");

    a_basic_no_pre: assert property (@(posedge clk_i)
        !ENHANCED |-> s_q.cpre == '0)
        else $error("basic cell received a preset");

endmodule : pio_regs

// ---- test/pio_pins_model.sv ----
// ==========================================================================
// board around the pads: other drivers and a pull-up on every pin
// ==========================================================================
module pio_pins_model #(
    parameter int N = 8 // pins on the board
) (
    // design side of the pads
    input wire logic [N-1:0] drv_i,
    input wire logic [N-1:0] drv_oe_n_i,
    // other devices on the board
    input wire logic [N-1:0] ext_val_i,
    input wire logic [N-1:0] ext_en_i,
    // resolved wire level and contention flag
    output logic [N-1:0] level_o,
    output logic clash_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // a released pin with no other driver is pulled high, never left stale
    assign level_o = (~drv_oe_n_i & drv_i) |
                     (drv_oe_n_i & ext_en_i & ext_val_i) |
                     (drv_oe_n_i & ~ext_en_i);
    // both sides driving one wire is a board fault
    assign clash_o = |(~drv_oe_n_i & ext_en_i);
endmodule : pio_pins_model

// ---- test/testbench.sv ----
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t mismatch %h vs %h", $time, g, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pio_pkg::*;

    // ======================================================================
    // signals
    // ======================================================================
    logic clk_i = 1'b0; // 25 mhz system clock
    logic rst_i = 1'b1; // synchronous reset
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
    logic [7:0] adr = 8'h00; // byte address
    logic [3:0] sel = 4'h0; // byte lanes
    logic [31:0] wdat = 32'h0000_0000; // write data
    logic [31:0] rdat, rdat2; // read data of both variants
    logic ack, ack2; // acknowledges of both variants
    logic [7:0] ext_val = 8'h00, ext_en = 8'h00; // board drivers
    logic [7:0] pin, pout, poe_n, pin2, pout2, poe_n2; // pad nets
    logic clash, clash2; // contention flags
    logic [31:0] r, r2; // last read values
    int error_cnt = 0, compares = 0, cycles = 0; // bookkeeping
    logic [7:0] reg_adr [6] = '{ADDR_MODE, ADDR_USE, ADDR_INV, ADDR_INIT,
                                ADDR_DOUT, ADDR_OE}; // plain registers
    logic [31:0] reg_msk [6] = '{32'h0000_FFFF, 32'h0000_00FF, 32'h0000_00FF,
                                 32'h0000_00FF, 32'h0000_00FF,
                                 32'h0000_00FF}; // implemented bits

    // ======================================================================
    // enhanced and basic variants on one shared bus
    // ======================================================================
    pio_regs dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pad_i(pin), .pad_o(pout), .pad_oe_n_o(poe_n));
    pio_regs #(.N_PINS(8), .ENHANCED(1'b0)) dut_basic (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat2),
        .wb_ack_o(ack2), .pad_i(pin2), .pad_o(pout2), .pad_oe_n_o(poe_n2));
    pio_pins_model #(.N(8)) board (.drv_i(pout), .drv_oe_n_i(poe_n),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin),
        .clash_o(clash));
    pio_pins_model #(.N(8)) board2 (.drv_i(pout2), .drv_oe_n_i(poe_n2),
        .ext_val_i(ext_val), .ext_en_i(ext_en), .level_o(pin2),
        .clash_o(clash2));

    // ======================================================================
    // clock, timeout and verdict
    // ======================================================================
    initial forever #20 clk_i = ~clk_i;

    // a hang ends the run as a failure
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // ======================================================================
    // bus cycles: hold the request until ack is sampled high
    // ======================================================================
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        r2 = rdat2;
        `CHK({ack, ack2}, 2'b11);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) error_cnt++;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd

    // let registered pin logic and synchronisers catch up
    task automatic settle();
        repeat (5) @(posedge clk_i);
    endtask : settle

    // ======================================================================
    // main sequence
    // ======================================================================
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // drivers off and global controls clear out of reset
        `CHK(poe_n, 8'hFF);
        `CHK(poe_n2, 8'hFF);
        rd(ADDR_CTRL);
        `CHK(r, 32'h0000_0000);
        rd(8'h28);
        `CHK(r, 32'h0000_0000);
        // reset value, implemented width and readback of each plain register
        for (int i = 0; i < 6; i++) begin
            rd(reg_adr[i]);
            `CHK(r, 32'h0000_0000);
            `CHK(r2, 32'h0000_0000);
            wr(reg_adr[i], 32'hFFFF_FFFF);
            rd(reg_adr[i]);
            `CHK(r, reg_msk[i]);
            `CHK(r2, reg_msk[i]);
            wr(reg_adr[i], 32'h0000_0000);
        end
        // byte lane merge keeps the untouched lane
        wr(ADDR_MODE, 32'h0000_5555);
        xfer(1'b1, ADDR_MODE, 32'h0000_AA00, 4'h2);
        rd(ADDR_MODE);
        `CHK(r, 32'h0000_AA55);
        // output only, then inversion, then global enable off
        wr(ADDR_MODE, 32'h0000_5555);
        wr(ADDR_DOUT, 32'h0000_00A5);
        wr(ADDR_CTRL, 32'h0000_0001);
        settle();
        `CHK(poe_n, 8'h00);
        `CHK(pout, 8'hA5);
        wr(ADDR_INV, 32'h0000_000F);
        settle();
        `CHK(pout, 8'hAA);
        wr(ADDR_CTRL, 32'h0000_0000);
        settle();
        `CHK(poe_n, 8'hFF);
        wr(ADDR_INV, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0001);
        // bidirectional, driver follows each pin's own enable
        wr(ADDR_MODE, 32'h0000_AAAA);
        wr(ADDR_OE, 32'h0000_003C);
        settle();
        `CHK(poe_n, 8'hC3);
        `CHK(poe_n2, 8'hC3);
        // mode 3: native open drain on enhanced, bidirectional on basic
        wr(ADDR_MODE, 32'h0000_FFFF);
        wr(ADDR_DOUT, 32'h0000_000F);
        wr(ADDR_OE, 32'h0000_00FF);
        settle();
        `CHK(poe_n, 8'h0F);
        `CHK(pout[7:4], 4'h0);
        `CHK(poe_n2, 8'h00);
        rd(ADDR_STAT);
        `CHK(r[7:0], 8'h0F);
        // input only: never drives, core capture sees the board
        wr(ADDR_MODE, 32'h0000_0000);
        settle();
        ext_en <= 8'hFF;
        ext_val <= 8'h5A;
        settle();
        `CHK(poe_n, 8'hFF);
        rd(ADDR_STAT);
        `CHK(r[7:0], 8'h5A);
        `CHK(r2[7:0], 8'h5A);
        ext_en <= 8'h00;
        // cell register in the output path
        wr(ADDR_MODE, 32'h0000_5555);
        wr(ADDR_USE, 32'h0000_00FF);
        wr(ADDR_INIT, 32'h0000_00F0);
        wr(ADDR_DOUT, 32'h0000_00FF);
        settle();
        `CHK(pout, 8'hFF);
        wr(ADDR_ACLR, 32'h0000_00FF);
        settle();
        `CHK(pout, 8'hF0);
        rd(ADDR_STAT);
        `CHK(r[23:16], 8'hF0);
        `CHK(r2[23:16], 8'hF0);
        wr(ADDR_ACLR, 32'h0000_0000);
        wr(ADDR_DOUT, 32'h0000_0000);
        wr(ADDR_APRE, 32'h0000_00FF);
        settle();
        `CHK(pout, 8'hF0);
        `CHK(pout2, 8'h00);
        rd(ADDR_STAT);
        `CHK(r2[23:16], 8'h00);
        wr(ADDR_APRE, 32'h0000_0000);
        wr(ADDR_DOUT, 32'h0000_00FF);
        wr(ADDR_CTRL, 32'h0000_0003);
        settle();
        `CHK(pout, 8'hF0);
        `CHK(pout2, 8'hF0);
        wr(ADDR_CTRL, 32'h0000_0001);
        // cell register as input register
        wr(ADDR_USE, 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_0000);
        settle();
        ext_en <= 8'hFF;
        ext_val <= 8'h96;
        settle();
        rd(ADDR_STAT);
        `CHK(r, 32'h0096_0096);
        `CHK(r2, 32'h0096_0096);
        `CHK({clash, clash2}, 2'b00);
        give_verdict();
    end
endmodule : testbench
